//--- verilog/dsd_decoder.sv
// Purpose: data space decoder, register file, scratch registers and EEPROM access path
// Assumes: requests from the core are synchronous; peripherals answer reads combinationally
// Notes: one request at a time; ready low during an SRAM access or stall, not while the EEPROM is busy
`timescale 1ns/1ps
module dsd_decoder #(
   parameter int unsigned EE_ATOMIC_CYCLES = dsd_pkg::EE_ATOMIC_CYC,
   parameter int unsigned EE_SPLIT_CYCLES = dsd_pkg::EE_SPLIT_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire dsd_pkg::dsd_req_t req_i,
   output logic req_ready,
   output dsd_pkg::dsd_rsp_t rsp_o,
   output logic cpu_stall,
   output dsd_pkg::dsd_periph_t periph_o,
   input wire logic [7:0] periph_rdata,
   input wire logic [7:0] flag_events,
   output logic eeprom_busy
);
   import dsd_pkg::*;

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [7:0] regf_q [32];
   logic [7:0] sram_q [SRAM_BYTES];
   logic [7:0] eemem_q [EE_BYTES];
   logic [7:0] scr_q [3];
   logic [7:0] flags_q;
   logic [7:0] eedr_q;
   logic [8:0] eear_q;
   logic [1:0] mode_q;
   logic rdyie_q;
   logic arm_q;
   logic [2:0] arm_cnt_q;
   logic busy_q;
   logic [19:0] prog_cnt_q;
   logic [8:0] prog_addr_q;
   logic [7:0] prog_data_q;
   logic [1:0] prog_mode_q;
   dsd_state_t state_q;
   logic [2:0] stall_cnt_q;
   dsd_rsp_t rsp_q;

   // ----------------------------------------------------------------
   // address formation
   // ----------------------------------------------------------------
   wire [4:0] ptr_lo_idx = 5'd26 + 5'({req_i.ptr, 1'b0});
   wire [4:0] ptr_hi_idx = ptr_lo_idx + 5'd1;
   wire [15:0] ptr_val = {regf_q[ptr_hi_idx], regf_q[ptr_lo_idx]};
   wire [15:0] ptr_dec = ptr_val - 16'h0001;
   wire [15:0] ptr_inc = ptr_val + 16'h0001;
   wire [15:0] disp_addr = ptr_val + {10'h000, req_i.disp};
   wire [15:0] port_addr = {10'h000, req_i.io_addr} + IO_BASE;
   wire is_bit_op = req_i.op == OP_BIT_SET || req_i.op == OP_BIT_CLR || req_i.op == OP_BIT_TEST;
   wire is_port = req_i.op == OP_PORT || is_bit_op;
   // port and bit ops only carry six address bits, so 0x60 and up stay out of reach
   wire [15:0] eff_addr = (req_i.op == OP_DIRECT) ? req_i.addr :
      (req_i.op == OP_DISP) ? disp_addr :
      (req_i.op == OP_PREDEC) ? ptr_dec :
      is_port ? port_addr : ptr_val;

   // ----------------------------------------------------------------
   // region decode
   // ----------------------------------------------------------------
   wire in_regf = eff_addr < IO_BASE;
   wire in_io = !in_regf && eff_addr < XIO_BASE;
   wire in_xio = eff_addr >= XIO_BASE && eff_addr < SRAM_BASE;
   wire in_sram = eff_addr >= SRAM_BASE && eff_addr < DATA_TOP;
   wire [5:0] io_idx = 6'(eff_addr - IO_BASE);
   wire [9:0] sram_idx = 10'(eff_addr - SRAM_BASE);
   wire bit_ok = !req_i.io_addr[5];
   wire op_ok = !is_bit_op || bit_ok;
   wire take = req_i.valid && req_ready;
   wire wr = take && op_ok && (req_i.op == OP_BIT_SET || req_i.op == OP_BIT_CLR ||
      (req_i.we && !is_bit_op));
   wire ptr_upd = take && (req_i.op == OP_PREDEC || req_i.op == OP_POSTINC);
   wire [15:0] ptr_new = (req_i.op == OP_PREDEC) ? ptr_dec : ptr_inc;

   // local io hits
   wire hit_flags = in_io && io_idx == IO_FLAGS;
   wire hit_ctl = in_io && io_idx == IO_EECTL;
   wire hit_dat = in_io && io_idx == IO_EEDAT;
   wire hit_adl = in_io && io_idx == IO_EEADL;
   wire hit_adh = in_io && io_idx == IO_EEADH;
   logic [2:0] scr_hit;
   wire hit_local = hit_flags || hit_ctl || hit_dat || hit_adl || hit_adh || (|scr_hit);
   wire hit_periph = (in_io && !hit_local) || in_xio;

   // ----------------------------------------------------------------
   // read value and write merge
   // ----------------------------------------------------------------
   wire [7:0] bit_onehot = 8'h01 << req_i.bit_idx;
   wire [7:0] wmask = is_bit_op ? bit_onehot : 8'hff;
   wire [7:0] wval = (req_i.op == OP_BIT_SET) ? bit_onehot :
      (req_i.op == OP_BIT_CLR) ? 8'h00 : req_i.wdata;
   wire [7:0] ctl_rd = {2'b00, mode_q, rdyie_q, arm_q, busy_q, 1'b0};
   wire [7:0] scr_rd = scr_hit[0] ? scr_q[0] : scr_hit[1] ? scr_q[1] : scr_q[2];
   wire [7:0] local_rd = hit_flags ? flags_q : hit_ctl ? ctl_rd : hit_dat ? eedr_q :
      hit_adl ? eear_q[7:0] : hit_adh ? {7'h00, eear_q[8]} : scr_rd;
   wire [7:0] rd_val = in_regf ? regf_q[eff_addr[4:0]] :
      in_sram ? sram_q[sram_idx] :
      hit_periph ? periph_rdata :
      (in_io && hit_local) ? local_rd : RST_BYTE;
   // for bit ops only the addressed bit moves; the rest keep their current value
   wire [7:0] merged = (rd_val & ~wmask) | (wval & wmask);

   // ----------------------------------------------------------------
   // EEPROM control decode
   // ----------------------------------------------------------------
   wire ctl_wr = wr && hit_ctl;
   wire arm_set = ctl_wr && merged[CTL_ARM] && !merged[CTL_PROG];
   // strobe without a live arm does nothing: guards against stray writes
   wire prog_go = ctl_wr && merged[CTL_PROG] && arm_q && !busy_q;
   wire rd_go = ctl_wr && merged[CTL_RD] && !busy_q;
   wire prog_done = busy_q && prog_cnt_q == 20'h00001;
   wire [7:0] old_byte = eemem_q[prog_addr_q];
   wire [7:0] prog_byte = (prog_mode_q == MODE_ERASE) ? ERASED_BYTE :
      (prog_mode_q == MODE_WRITE) ? (old_byte & prog_data_q) : prog_data_q;
   wire [19:0] prog_load = (mode_q == MODE_ATOMIC) ? 20'(EE_ATOMIC_CYCLES) :
      20'(EE_SPLIT_CYCLES);
   wire [7:0] flag_clr = (wr && hit_flags) ? (wval & wmask) : 8'h00;

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign req_ready = state_q == ST_IDLE;
   assign cpu_stall = state_q == ST_STALL;
   assign rsp_o = rsp_q;
   assign eeprom_busy = busy_q;
   // peripherals see the same merged byte, so they need no bit logic of their own
   assign periph_o.we = wr && hit_periph;
   assign periph_o.re = take && hit_periph && !(req_i.we && !is_bit_op);
   assign periph_o.addr = eff_addr[7:0];
   assign periph_o.wdata = merged;

   // ----------------------------------------------------------------
   // scratch registers
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_scr
         assign scr_hit[g] = in_io && io_idx == IO_SCR[g];
         always_ff @(posedge clk)
         begin
            if (!rst_b)
               scr_q[g] <= RST_BYTE;
            else if (wr && scr_hit[g])
               scr_q[g] <= merged;
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // register file and SRAM
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (wr && in_regf)
         regf_q[eff_addr[4:0]] <= merged;
      if (ptr_upd)
      begin
         regf_q[ptr_lo_idx] <= ptr_new[7:0];
         regf_q[ptr_hi_idx] <= ptr_new[15:8];
      end
   end

   always_ff @(posedge clk)
   begin
      if (wr && in_sram)
         sram_q[sram_idx] <= merged;
   end

   // ----------------------------------------------------------------
   // flags and EEPROM registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         flags_q <= RST_BYTE;
      else
         flags_q <= (flags_q & ~flag_clr) | flag_events;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         eedr_q <= RST_BYTE;
         eear_q <= 9'h000;
         rdyie_q <= 1'b0;
         arm_q <= 1'b0;
         arm_cnt_q <= 3'h0;
      end
      else
      begin
         if (rd_go)
            eedr_q <= eemem_q[eear_q];
         else if (wr && hit_dat)
            eedr_q <= merged;
         if (wr && hit_adl && !busy_q)
            eear_q[7:0] <= merged;
         if (wr && hit_adh && !busy_q)
            eear_q[8] <= merged[0];
         if (ctl_wr)
            rdyie_q <= merged[CTL_RDYIE];
         if (arm_set)
         begin
            arm_q <= 1'b1;
            arm_cnt_q <= ARM_WINDOW_CYC;
         end
         else if (arm_q)
         begin
            arm_cnt_q <= arm_cnt_q - 3'h1;
            arm_q <= arm_cnt_q != 3'h1 && !prog_go;
         end
      end
   end

   // mode survives reset only while a write is running
   always_ff @(posedge clk)
   begin
      if (!rst_b && !busy_q)
         mode_q <= MODE_ATOMIC;
      else if (rst_b && ctl_wr && !busy_q)
         mode_q <= merged[CTL_MODE+1:CTL_MODE];
   end

   // ----------------------------------------------------------------
   // self-timed programming; reset does not cut a write short
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst_b && prog_go)
      begin
         busy_q <= 1'b1;
         prog_cnt_q <= prog_load;
         prog_addr_q <= eear_q;
         prog_data_q <= eedr_q;
         prog_mode_q <= mode_q;
      end
      else if (busy_q)
      begin
         busy_q <= !prog_done;
         prog_cnt_q <= prog_cnt_q - 20'h00001;
      end
      else if (!rst_b)
         busy_q <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (prog_done)
         eemem_q[prog_addr_q] <= prog_byte;
   end

   // ----------------------------------------------------------------
   // access sequencing and core stall
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         state_q <= ST_IDLE;
         stall_cnt_q <= 3'h0;
         rsp_q <= '0;
      end
      else
      begin
         rsp_q.done <= 1'b0;
         unique case (state_q)
            ST_IDLE:
            begin
               if (take)
               begin
                  rsp_q.rdata <= rd_val;
                  rsp_q.bit_val <= op_ok && rd_val[req_i.bit_idx];
                  if (in_sram)
                     state_q <= ST_SRAM;
                  else
                  begin
                     rsp_q.done <= 1'b1;
                     if (rd_go)
                     begin
                        state_q <= ST_STALL;
                        stall_cnt_q <= RD_STALL_CYC;
                     end
                     else if (prog_go)
                     begin
                        state_q <= ST_STALL;
                        stall_cnt_q <= WR_STALL_CYC;
                     end
                  end
               end
            end
            ST_SRAM:
            begin
               rsp_q.done <= 1'b1;
               state_q <= ST_IDLE;
            end
            ST_STALL:
            begin
               stall_cnt_q <= stall_cnt_q - 3'h1;
               if (stall_cnt_q == 3'h1)
                  state_q <= ST_IDLE;
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end
endmodule : dsd_decoder

//--- verilog/dsd_pkg.sv
// Purpose: shared constants and types for the data space decoder
// Assumes: 250 MHz core clock; largest variant (1K SRAM, 512 byte EEPROM)
// Notes: io addresses are 6-bit port addresses; data address = io + IO_BASE
package dsd_pkg;
   // ----------------------------------------------------------------
   // data space map
   // ----------------------------------------------------------------
   localparam logic [15:0] IO_BASE = 16'h0020;
   localparam logic [15:0] XIO_BASE = 16'h0060;
   localparam logic [15:0] SRAM_BASE = 16'h0100;
   localparam logic [15:0] DATA_TOP = 16'h0500;
   localparam int unsigned EE_BYTES = 512;
   localparam int unsigned SRAM_BYTES = 1024;
   // ----------------------------------------------------------------
   // local io registers (port addresses)
   // ----------------------------------------------------------------
   localparam logic [5:0] IO_FLAGS = 6'h1c;
   localparam logic [5:0] IO_EECTL = 6'h1f;
   localparam logic [5:0] IO_EEDAT = 6'h20;
   localparam logic [5:0] IO_EEADL = 6'h21;
   localparam logic [5:0] IO_EEADH = 6'h22;
   localparam logic [5:0] IO_SCR [3] = '{6'h1e, 6'h2a, 6'h2b};
   // control register fields
   localparam int unsigned CTL_RD = 0;
   localparam int unsigned CTL_PROG = 1;
   localparam int unsigned CTL_ARM = 2;
   localparam int unsigned CTL_RDYIE = 3;
   localparam int unsigned CTL_MODE = 4;
   localparam logic [1:0] MODE_ATOMIC = 2'h0;
   localparam logic [1:0] MODE_ERASE = 2'h1;
   localparam logic [1:0] MODE_WRITE = 2'h2;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_PS = 4000;
   localparam logic [2:0] ARM_WINDOW_CYC = 3'h4;
   localparam logic [2:0] RD_STALL_CYC = 3'h4;
   localparam logic [2:0] WR_STALL_CYC = 3'h2;
   localparam int unsigned EE_ATOMIC_US = 3400;
   localparam int unsigned EE_SPLIT_US = 1800;
   localparam int unsigned EE_ATOMIC_CYC = (EE_ATOMIC_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned EE_SPLIT_CYC = (EE_SPLIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_DIRECT = 4'h0, OP_DISP = 4'h1, OP_IND = 4'h2, OP_PREDEC = 4'h3, OP_POSTINC = 4'h4,
      OP_PORT = 4'h5, OP_BIT_SET = 4'h6, OP_BIT_CLR = 4'h7, OP_BIT_TEST = 4'h8
   } dsd_op_t;
   typedef enum logic [1:0] {PTR_X = 2'h0, PTR_Y = 2'h1, PTR_Z = 2'h2} dsd_ptr_t;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SRAM = 2'b01, ST_STALL = 2'b11} dsd_state_t;
   typedef struct packed {
      logic valid;
      logic we;
      dsd_op_t op;
      dsd_ptr_t ptr;
      logic [5:0] disp;
      logic [15:0] addr;
      logic [5:0] io_addr;
      logic [2:0] bit_idx;
      logic [7:0] wdata;
   } dsd_req_t;
   typedef struct packed {
      logic done;
      logic [7:0] rdata;
      logic bit_val;
   } dsd_rsp_t;
   typedef struct packed {
      logic we;
      logic re;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dsd_periph_t;
endpackage : dsd_pkg

//--- test/dsd_decoder_monitor.sv
// Purpose: port-level checker for the data space decoder
// Assumes: one clock domain, synchronous active-low reset
// Notes: eeprom timing is checked against the parameters handed in by the bind
`timescale 1ns/1ps
module dsd_decoder_monitor #(
   parameter int unsigned EE_ATOMIC_CYCLES = 10,
   parameter int unsigned EE_SPLIT_CYCLES = 6
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire dsd_pkg::dsd_req_t req_i,
   input wire logic req_ready,
   input wire dsd_pkg::dsd_rsp_t rsp_o,
   input wire logic cpu_stall,
   input wire dsd_pkg::dsd_periph_t periph_o,
   input wire logic [7:0] periph_rdata,
   input wire logic [7:0] flag_events,
   input wire logic eeprom_busy
);
   import dsd_pkg::*;
   logic take;
   logic ctl_wr;
   logic bit_wr;
   logic [7:0] mask;
   // run length is kept through reset, since a write survives it
   logic [19:0] busy_run_q;
   assign take = req_i.valid && req_ready;
   assign ctl_wr = take && req_i.op == OP_PORT && req_i.we && req_i.io_addr == IO_EECTL;
   assign bit_wr = take && (req_i.op == OP_BIT_SET || req_i.op == OP_BIT_CLR);
   assign mask = 8'h01 << req_i.bit_idx;
   always_ff @(posedge clk)
   begin
      busy_run_q <= eeprom_busy ? busy_run_q + 20'h00001 : 20'h00000;
   end
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence sram_take_s;
      take && req_i.op == OP_DIRECT && req_i.addr >= SRAM_BASE && req_i.addr < DATA_TOP;
   endsequence
   sequence arm_prog_s;
      ctl_wr && req_i.wdata[2:0] == 3'h4 ##[1:3] ctl_wr && req_i.wdata[2:0] == 3'h2 &&
      !eeprom_busy;
   endsequence
   sequence ee_read_s;
      ctl_wr && req_i.wdata == 8'h01 && !eeprom_busy;
   endsequence
   chk_sram_two_cyc: assert property (
      sram_take_s |=> !req_ready && !rsp_o.done ##1 rsp_o.done && req_ready)
      else $error("sram access not done in two cycles");
   chk_port_one_cyc: assert property (take && req_i.op == OP_PORT |=> rsp_o.done)
      else $error("port access not done next cycle");
   chk_port_offset: assert property (
      take && req_i.op == OP_PORT && (periph_o.we || periph_o.re)
      |-> periph_o.addr == {2'b00, req_i.io_addr} + 8'h20)
      else $error("port address not offset by 0x20");
   chk_bit_range: assert property (
      bit_wr && req_i.io_addr >= 6'h20 |-> !periph_o.we ##1 rsp_o.done && !rsp_o.bit_val)
      else $error("bit op acted above io 0x1f");
   chk_bit_merge: assert property (
      bit_wr && periph_o.we |-> periph_o.wdata == ((req_i.op == OP_BIT_SET) ?
      (periph_rdata | mask) : (periph_rdata & ~mask)))
      else $error("bit op touched other bits");
   chk_xio_rdata: assert property (
      take && periph_o.re |=> rsp_o.done && rsp_o.rdata == $past(periph_rdata))
      else $error("peripheral read data lost");
   chk_rd_stall: assert property (
      ee_read_s |=> rsp_o.done && cpu_stall ##1 cpu_stall [*3] ##1 !cpu_stall && req_ready)
      else $error("eeprom read stall not four cycles");
   chk_wr_stall: assert property (
      arm_prog_s |=> cpu_stall && eeprom_busy ##1 cpu_stall ##1 !cpu_stall && req_ready)
      else $error("eeprom write stall not two cycles");
   chk_busy_span: assert property ($fell(eeprom_busy) |->
      busy_run_q == EE_ATOMIC_CYCLES || busy_run_q == EE_SPLIT_CYCLES)
      else $error("eeprom busy span wrong");
   chk_stall_block: assert property (cpu_stall |-> !req_ready)
      else $error("request taken during stall");
   chk_unmapped: assert property (
      take && req_i.op == OP_DIRECT && req_i.addr >= DATA_TOP
      |-> !periph_o.we ##1 rsp_o.rdata == 8'h00)
      else $error("unmapped access not inert");
endmodule : dsd_decoder_monitor

//--- test/dsd_periph_model.sv
// Purpose: byte store standing in for the peripherals behind the io bus
// Assumes: reads answered in the same cycle, writes land on the edge
// Notes: without a read strobe the inverse is shown so a lost strobe shows up
`timescale 1ns/1ps
module dsd_periph_model (
   input wire logic clk,
   input wire dsd_pkg::dsd_periph_t periph_o,
   output logic [7:0] periph_rdata
);
   import dsd_pkg::*;
   logic [7:0] mem_q [256];
   initial
   begin
      for (int i = 0; i < 256; i++)
      begin
         mem_q[i] = i[7:0] ^ 8'ha5;
      end
   end
   always @(posedge clk)
   begin
      if (periph_o.we)
      begin
         mem_q[periph_o.addr] <= periph_o.wdata;
      end
   end
   assign periph_rdata = periph_o.re ? mem_q[periph_o.addr] : ~mem_q[periph_o.addr];
endmodule : dsd_periph_model

//--- test/dsd_decoder_bench.sv
// Purpose: self-checking bench for the data space decoder
// Assumes: one request in flight; shortened eeprom program times
// Notes: peripherals are a byte store model
`timescale 1ns/1ps
module dsd_decoder_bench;
   import dsd_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   dsd_req_t req_i = '0;
   logic req_ready;
   logic cpu_stall;
   logic eeprom_busy;
   dsd_rsp_t rsp_o;
   dsd_periph_t periph_o;
   logic [7:0] periph_rdata;
   logic [7:0] flag_events = 8'h00;
   logic [7:0] last_rd;
   logic last_bv;
   int failures = 0;
   int checked = 0;
   always #2 clk = ~clk;
   dsd_decoder #(.EE_ATOMIC_CYCLES(10), .EE_SPLIT_CYCLES(6)) i_dut (.clk(clk), .rst_b(rst_b),
      .req_i(req_i), .req_ready(req_ready), .rsp_o(rsp_o), .cpu_stall(cpu_stall),
      .periph_o(periph_o), .periph_rdata(periph_rdata), .flag_events(flag_events),
      .eeprom_busy(eeprom_busy));
   dsd_periph_model i_periph (.clk(clk), .periph_o(periph_o), .periph_rdata(periph_rdata));
   task automatic final_report;
      if (failures == 0 && checked > 0)
      begin
         $display("Finished cleanly");
      end
      else
      begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("FAIL %0t got %h want %h", $time, got, exp);
      end
   endtask : cmp
   // request held from a rising edge until the edge that samples ready high
   task automatic go(input dsd_op_t op, input logic we, input logic [15:0] a,
      input logic [2:0] b, input logic [7:0] d);
      int n;
      @(posedge clk);
      req_i <= '{valid: 1'b1, we: we, op: op, ptr: dsd_ptr_t'(a[9:8]), disp: a[5:0],
         addr: a, io_addr: a[5:0], bit_idx: b, wdata: d};
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (req_ready !== 1'b1 && n < 20);
      @(posedge clk);
      req_i <= '0;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (rsp_o.done !== 1'b1 && n < 4);
      last_rd = rsp_o.rdata;
      last_bv = rsp_o.bit_val;
      cmp({7'h00, rsp_o.done}, 8'h01);
   endtask : go
   task automatic wr(input dsd_op_t op, input logic [15:0] a, input logic [7:0] d);
      go(op, 1'b1, a, 3'h0, d);
   endtask : wr
   task automatic rd(input dsd_op_t op, input logic [15:0] a, input logic [7:0] e);
      go(op, 1'b0, a, 3'h0, 8'h00);
      cmp(last_rd, e);
   endtask : rd
   task automatic ee_prog(input logic [7:0] d, input logic [1:0] m);
      wr(OP_PORT, 16'h0020, d);
      wr(OP_PORT, 16'h001f, {2'b00, m, 4'h4});
      wr(OP_PORT, 16'h001f, {2'b00, m, 4'h2});
   endtask : ee_prog
   task automatic ee_wait;
      int n;
      n = 0;
      do
      begin
         go(OP_PORT, 1'b0, 16'h001f, 3'h0, 8'h00);
         n++;
      end
      while (last_rd[1] !== 1'b0 && n < 30);
   endtask : ee_wait
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         wr(OP_PORT, {10'h000, IO_SCR[i]}, 8'h50 + i[7:0]);
         rd(OP_DIRECT, {10'h000, IO_SCR[i]} + IO_BASE, 8'h50 + i[7:0]);
      end
      go(OP_BIT_CLR, 1'b0, 16'h001e, 3'h4, 8'h00);
      rd(OP_PORT, 16'h001e, 8'h40);
      go(OP_BIT_TEST, 1'b0, 16'h001e, 3'h6, 8'h00);
      cmp({7'h00, last_bv}, 8'h01);
      go(OP_BIT_SET, 1'b0, 16'h002a, 3'h1, 8'h00);
      rd(OP_PORT, 16'h002a, 8'h51);
      wr(OP_PORT, 16'h001c, 8'hff);
      @(posedge clk);
      flag_events <= 8'h05;
      @(posedge clk);
      flag_events <= 8'h00;
      rd(OP_PORT, 16'h001c, 8'h05);
      go(OP_BIT_SET, 1'b0, 16'h001c, 3'h2, 8'h00);
      rd(OP_DIRECT, 16'h003c, 8'h01);
      wr(OP_PORT, 16'h0005, 8'h0f);
      go(OP_BIT_SET, 1'b0, 16'h0005, 3'h7, 8'h00);
      go(OP_BIT_CLR, 1'b0, 16'h0005, 3'h0, 8'h00);
      rd(OP_DIRECT, 16'h0025, 8'h8e);
      wr(OP_DIRECT, 16'h0080, 8'hc3);
      rd(OP_DIRECT, 16'h0080, 8'hc3);
      wr(OP_DIRECT, 16'h001a, 8'h10);
      wr(OP_DIRECT, 16'h001b, 8'h01);
      wr(OP_IND, 16'h0000, 8'h77);
      rd(OP_DIRECT, 16'h0110, 8'h77);
      wr(OP_POSTINC, 16'h0000, 8'h78);
      rd(OP_DIRECT, 16'h001a, 8'h11);
      rd(OP_PREDEC, 16'h0000, 8'h78);
      rd(OP_DIRECT, 16'h001a, 8'h10);
      wr(OP_DIRECT, 16'h001c, 8'hc0);
      wr(OP_DIRECT, 16'h001d, 8'h04);
      wr(OP_DISP, 16'h013f, 8'h9c);
      rd(OP_DIRECT, 16'h04ff, 8'h9c);
      wr(OP_DIRECT, 16'h001e, 8'h3e);
      wr(OP_DIRECT, 16'h001f, 8'h00);
      rd(OP_IND, 16'h0200, 8'h40);
      wr(OP_DIRECT, 16'h0500, 8'h12);
      rd(OP_DIRECT, 16'h0500, 8'h00);
      wr(OP_PORT, 16'h0021, 8'h07);
      wr(OP_PORT, 16'h0022, 8'h01);
      ee_prog(8'ha5, MODE_ATOMIC);
      ee_wait();
      cmp(last_rd & 8'h02, 8'h00);
      wr(OP_PORT, 16'h001f, 8'h01);
      rd(OP_PORT, 16'h0020, 8'ha5);
      wr(OP_PORT, 16'h0020, 8'h3c);
      wr(OP_PORT, 16'h001f, 8'h02);
      cmp({7'h00, eeprom_busy}, 8'h00);
      wr(OP_PORT, 16'h001f, 8'h04);
      repeat (6) @(posedge clk);
      wr(OP_PORT, 16'h001f, 8'h02);
      cmp({7'h00, eeprom_busy}, 8'h00);
      ee_prog(8'h66, MODE_ATOMIC);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      cmp({7'h00, eeprom_busy}, 8'h01);
      ee_wait();
      wr(OP_PORT, 16'h0021, 8'h07);
      wr(OP_PORT, 16'h0022, 8'h01);
      wr(OP_PORT, 16'h001f, 8'h01);
      rd(OP_PORT, 16'h0020, 8'h66);
      // write-only mode can only clear bits of the old byte
      ee_prog(8'h3c, MODE_WRITE);
      ee_wait();
      wr(OP_PORT, 16'h001f, 8'h01);
      rd(OP_PORT, 16'h0020, 8'h24);
      ee_prog(8'h00, MODE_ERASE);
      ee_wait();
      wr(OP_PORT, 16'h001f, 8'h01);
      rd(OP_PORT, 16'h0020, 8'hff);
      final_report();
   end
   initial
   begin
      repeat (4000) @(posedge clk);
      failures++;
      final_report();
   end
endmodule : dsd_decoder_bench
bind dsd_decoder dsd_decoder_monitor #(.EE_ATOMIC_CYCLES(EE_ATOMIC_CYCLES),
   .EE_SPLIT_CYCLES(EE_SPLIT_CYCLES)) u_mon (.clk(clk), .rst_b(rst_b), .req_i(req_i),
   .req_ready(req_ready), .rsp_o(rsp_o), .cpu_stall(cpu_stall), .periph_o(periph_o),
   .periph_rdata(periph_rdata), .flag_events(flag_events), .eeprom_busy(eeprom_busy));
